/* tip_map.svh */
// Purpose: Named constants for the timer input pin assignment block
// Assumes: Included by bare name from the package and the design modules
// Notes: Definitions only; no logic lives here
`ifndef TIP_MAP_SVH
`define TIP_MAP_SVH

// ****************************************************************
// Pin function codes
// ****************************************************************
`define TIP_FC_IDLE       4'h0
`define TIP_FC_BTRIG      4'h1
`define TIP_FC_AGATE      4'h2
`define TIP_FC_AGATE_BTRG 4'h3
`define TIP_FC_BCLK       4'h4
`define TIP_FC_ATRIG      4'h5
`define TIP_FC_AGATE_BCLK 4'h6
`define TIP_FC_ATRG_BTRG  4'h7
`define TIP_FC_CLK_UPDN   4'h8
`define TIP_FC_ADIR_BCLK  4'h9
`define TIP_FC_TRG_UPDN   4'ha
`define TIP_FC_ADIR       4'hb
`define TIP_FC_AUTODISCR  4'hc
`define TIP_FC_ATRG_BCLK  4'hd
`define TIP_FC_ACLK_BTRG  4'he
`define TIP_FC_ATRG_BGATE 4'hf

// ****************************************************************
// Edge select codes and prescaler timing
// ****************************************************************
`define TIP_ESEL_NONE 2'h0
`define TIP_ESEL_RISE 2'h1
`define TIP_ESEL_FALL 2'h2
`define TIP_ESEL_BOTH 2'h3
// Prescaler clock runs at one third of the system clock
`define TIP_PRESC_RATIO 3

`endif

/* tip_pkg.sv */
// Purpose: Types and shared functions of the timer input pin assignment
// Assumes: tip_map.svh supplies the numeric constants
// Notes: No timescale; package only
`default_nettype none
`include "tip_map.svh"

package tip_pkg;

   typedef logic [3:0] tip_fcode_t;
   typedef logic [1:0] tip_esel_t;

   // Where the count direction comes from
   typedef enum logic [1:0] {
      TIP_DIR_SOFT,
      TIP_DIR_LEVEL,
      TIP_DIR_EDGE,
      TIP_DIR_PHASE
   } tip_dir_src_t;

   // True when a sampled transition matches the programmed edge choice
   function automatic logic tip_edge_hit(input tip_esel_t esel,
                                         input logic rise,
                                         input logic fall);
      logic hit;
      hit = 1'b0;
      case (esel)
         `TIP_ESEL_RISE: hit = rise;
         `TIP_ESEL_FALL: hit = fall;
         `TIP_ESEL_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : tip_edge_hit

endpackage : tip_pkg

`default_nettype wire

/* tip_pin_sync.sv */
// Purpose: Synchronise one timer input pin and detect its edges
// Assumes: Pin is asynchronous to clk_sys
// Notes: Two flops before any logic reads the pin
`timescale 1ns/1ps
`default_nettype none
`include "tip_map.svh"

module tip_pin_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Pin and edge choice
   input wire logic pin,
   input wire tip_pkg::tip_esel_t edge_sel,
   // Synchronised results
   output logic level,
   output logic rise,
   output logic fall,
   output logic hit
);
   import tip_pkg::*;

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ****************************************************************
   // Synchroniser and history
   // ****************************************************************
   // Only sync_q reads meta_q, so metastability stays contained
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge decode on the synchronised level
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
   assign hit = tip_edge_hit(edge_sel, rise, fall);

endmodule : tip_pin_sync

`default_nettype wire

/* tip_pin_assign.sv */
// Purpose: Route two timer input pins to gate, trigger, clock and
//          direction roles under a 4-bit function code
// Assumes: Counter and holding registers sit outside, the prescaler divider (div_q) inside;
//          they consume the one-cycle request pulses made here
// Notes: All outputs are registered, so each answers one clock after
//        the synchronised pin event
`timescale 1ns/1ps
`default_nettype none
`include "tip_map.svh"

module tip_pin_assign #(
   parameter int PRESC_RATIO = `TIP_PRESC_RATIO
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // External timer pins
   input wire logic timer_input_a,
   input wire logic timer_input_b,
   // Configuration
   input wire tip_pkg::tip_fcode_t pin_function_code,
   input wire tip_pkg::tip_esel_t input_a_edge_select,
   input wire tip_pkg::tip_esel_t input_b_edge_select,
   input wire logic soft_direction_bit,
   input wire logic first_register_mode_bit,
   input wire logic bivalue_mode_en,
   // Counter controls
   output logic count_tick_q,
   output logic count_up_q,
   output logic ext_clock_q,
   // Holding register requests
   output logic load_req_q,
   output logic capture0_q,
   output logic capture1_q
);
   import tip_pkg::*;

   localparam int PW = $clog2(PRESC_RATIO);

   // Refuse a divider that cannot make a prescaler tick
   if (PRESC_RATIO < 2)
   begin : g_bad_ratio
      $error("PRESC_RATIO must be at least 2");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic a_lvl;
   logic a_rise;
   logic a_fall;
   logic a_ev;
   logic b_lvl;
   logic b_rise;
   logic b_fall;
   logic b_ev;

   // Edges narrower than a system period are missed; the source
   // keeps the minimum widths
   tip_pin_sync u_sync_a (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin(timer_input_a),
      .edge_sel(input_a_edge_select),
      .level(a_lvl),
      .rise(a_rise),
      .fall(a_fall),
      .hit(a_ev)
   );

   tip_pin_sync u_sync_b (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin(timer_input_b),
      .edge_sel(input_b_edge_select),
      .level(b_lvl),
      .rise(b_rise),
      .fall(b_fall),
      .hit(b_ev)
   );

   // ****************************************************************
   // Internal prescaler tick
   // ****************************************************************
   logic [PW-1:0] div_q;
   logic [PW-1:0] div_d;
   logic int_tick;

   assign int_tick = (div_q == PW'(PRESC_RATIO - 1));
   assign div_d = int_tick ? '0 : PW'(div_q + 1'b1);

   // Free running divider; it is not a clock, only a tick
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         div_q <= '0;
      else
         div_q <= div_d;
   end

   // ****************************************************************
   // Function code decode
   // ****************************************************************
   tip_fcode_t fc;
   logic use_a_trig;
   logic use_b_trig;
   logic gate_a;
   logic gate_b;
   logic ext_b;
   logic ext_a;
   logic gate_open;
   tip_dir_src_t dir_src;

   assign fc = pin_function_code;
   // Codes in which A is a register trigger
   assign use_a_trig = (fc == `TIP_FC_ATRIG)
                     | (fc == `TIP_FC_ATRG_BTRG)
                     | (fc == `TIP_FC_ATRG_BCLK)
                     | (fc == `TIP_FC_ATRG_BGATE);
   // Codes in which B is a capture trigger
   assign use_b_trig = (fc == `TIP_FC_BTRIG)
                     | (fc == `TIP_FC_AGATE_BTRG)
                     | (fc == `TIP_FC_ATRG_BTRG)
                     | (fc == `TIP_FC_ACLK_BTRG);
   assign gate_a = (fc == `TIP_FC_AGATE)
                 | (fc == `TIP_FC_AGATE_BTRG)
                 | (fc == `TIP_FC_AGATE_BCLK);
   assign gate_b = (fc == `TIP_FC_ATRG_BGATE);
   assign ext_b = (fc == `TIP_FC_BCLK)
                | (fc == `TIP_FC_AGATE_BCLK)
                | (fc == `TIP_FC_ADIR_BCLK)
                | (fc == `TIP_FC_ATRG_BCLK);
   assign ext_a = (fc == `TIP_FC_ACLK_BTRG);
   // Gate is open unless the selected gate pin is high
   assign gate_open = ~(gate_a & a_lvl) & ~(gate_b & b_lvl);

   // Direction source; every code outside 1000-1100 is software driven
   assign dir_src =
      ((fc == `TIP_FC_ADIR_BCLK) | (fc == `TIP_FC_ADIR)) ? TIP_DIR_LEVEL :
      ((fc == `TIP_FC_CLK_UPDN) | (fc == `TIP_FC_TRG_UPDN)) ? TIP_DIR_EDGE :
      (fc == `TIP_FC_AUTODISCR) ? TIP_DIR_PHASE : TIP_DIR_SOFT;

   // ****************************************************************
   // Next count tick
   // ****************************************************************
   logic ad_up;
   logic ad_down;
   logic tick_d;

   // Phase of B against A decides the step; A high blocks it
   assign ad_up = b_rise & ~a_lvl;
   assign ad_down = b_fall & ~a_lvl;

   always_comb
   begin
      tick_d = 1'b0;
      if (ext_b)
         tick_d = b_ev & gate_open;
      else if (ext_a)
         tick_d = a_ev;
      else if (fc == `TIP_FC_CLK_UPDN)
         tick_d = a_ev | b_ev;
      else if (fc == `TIP_FC_AUTODISCR)
         tick_d = ad_up | ad_down;
      else
         tick_d = int_tick & gate_open;
   end

   // ****************************************************************
   // Next direction
   // ****************************************************************
   logic dir_d;

   // B beats A when both edges land together in the edge modes
   always_comb
   begin
      dir_d = count_up_q;
      case (dir_src)
         TIP_DIR_SOFT: dir_d = soft_direction_bit;
         TIP_DIR_LEVEL: dir_d = a_lvl;
         TIP_DIR_EDGE:
         begin
            if (b_ev)
               dir_d = 1'b0;
            else if (a_ev)
               dir_d = 1'b1;
         end
         TIP_DIR_PHASE:
         begin
            if (ad_up)
               dir_d = 1'b1;
            else if (ad_down)
               dir_d = 1'b0;
         end
         default: dir_d = soft_direction_bit;
      endcase
   end

   // ****************************************************************
   // Holding register requests
   // ****************************************************************
   logic load_d;
   logic cap0_d;
   logic cap1_d;

   // Code 1010 uses A and B for direction only, so it is not listed
   assign load_d = use_a_trig & a_ev & ~first_register_mode_bit;
   assign cap0_d = use_a_trig & a_ev & first_register_mode_bit;
   assign cap1_d = use_b_trig & b_ev & ~bivalue_mode_en;

   // ****************************************************************
   // Output registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         count_tick_q <= 1'b0;
         count_up_q <= 1'b1;
         ext_clock_q <= 1'b0;
         load_req_q <= 1'b0;
         capture0_q <= 1'b0;
         capture1_q <= 1'b0;
      end
      else
      begin
         count_tick_q <= tick_d;
         count_up_q <= dir_d;
         ext_clock_q <= ext_a | ext_b;
         load_req_q <= load_d;
         capture0_q <= cap0_d;
         capture1_q <= cap1_d;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_idle_quiet;
      $past(fc) == `TIP_FC_IDLE |->
         !load_req_q && !capture0_q && !capture1_q;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("pin activity in code 0000");

   property p_soft_dir;
      $past(nrst) && $past(fc) == `TIP_FC_IDLE |->
         count_up_q == $past(soft_direction_bit);
   endproperty
   a_soft_dir: assert property (p_soft_dir)
      else $error("direction not from software bit");

   property p_b_capture;
      $past(fc == `TIP_FC_BTRIG && b_ev && !bivalue_mode_en) |->
         capture1_q;
   endproperty
   a_b_capture: assert property (p_b_capture)
      else $error("B trigger missed");

   property p_gate_a;
      $past(fc == `TIP_FC_AGATE && a_lvl) |-> !count_tick_q;
   endproperty
   a_gate_a: assert property (p_gate_a)
      else $error("tick while gate A high");

   property p_ext_b;
      $past(fc) == `TIP_FC_BCLK |-> count_tick_q == $past(b_ev);
   endproperty
   a_ext_b: assert property (p_ext_b)
      else $error("B clock tick mismatch");

   property p_a_load;
      $past(use_a_trig && a_ev && !first_register_mode_bit) |->
         load_req_q && !capture0_q;
   endproperty
   a_a_load: assert property (p_a_load)
      else $error("A trigger did not load");

   property p_updn_b_wins;
      $past(fc == `TIP_FC_CLK_UPDN && b_ev) |->
         count_tick_q && !count_up_q;
   endproperty
   a_updn_b_wins: assert property (p_updn_b_wins)
      else $error("B down step lost");

   property p_level_dir;
      $past(nrst) && $past(fc) == `TIP_FC_ADIR |-> count_up_q == $past(a_lvl);
   endproperty
   a_level_dir: assert property (p_level_dir)
      else $error("direction not following A");

   property p_autod_block;
      $past(fc == `TIP_FC_AUTODISCR && a_lvl) |-> !count_tick_q;
   endproperty
   a_autod_block: assert property (p_autod_block)
      else $error("step while A high");

   property p_bivalue;
      $past(bivalue_mode_en) |-> !capture1_q;
   endproperty
   a_bivalue: assert property (p_bivalue)
      else $error("B capture in bivalue mode");

   property p_presc_period;
      int_tick |=> !int_tick [*2] ##1 int_tick;
   endproperty
   a_presc_period: assert property (p_presc_period)
      else $error("prescaler tick not every third cycle");

   cover property (fc == `TIP_FC_AUTODISCR && ad_up ##1 count_tick_q);
   cover property (ext_clock_q && count_tick_q);
   cover property (capture1_q);
   cover property (load_req_q ##[1:20] capture0_q);

endmodule : tip_pin_assign

`default_nettype wire

/* tip_src_model.sv */
// Purpose: Event source model driving the two timer input pins
// Assumes: The bench requests pin levels on clk_sys rising edges
// Notes: A request waits until the pin has stood MIN_HOLD cycles
`timescale 1ns/1ps
`default_nettype none

module tip_src_model #(
   parameter int MIN_HOLD = 6
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Requested levels
   input wire logic want_a,
   input wire logic want_b,
   // Timer pins, always driven
   output logic pin_a,
   output logic pin_b
);
   int held_a;
   int held_b;
   logic mv_a;
   logic mv_b;

   // Six cycles covers pulse width, edge spacing and gate width at once;
   // B waits a cycle behind A so the two edges never coincide
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_a <= 1'b0;
         pin_b <= 1'b0;
         held_a <= 0;
         held_b <= 0;
      end
      else
      begin
         mv_a = (want_a != pin_a) && (held_a >= MIN_HOLD);
         mv_b = (want_b != pin_b) && (held_b >= MIN_HOLD) && !mv_a;
         pin_a <= mv_a ? want_a : pin_a;
         pin_b <= mv_b ? want_b : pin_b;
         held_a <= mv_a ? 0 : (held_a < 99 ? held_a + 1 : held_a);
         held_b <= mv_b ? 0 : (held_b < 99 ? held_b + 1 : held_b);
      end
   end
endmodule : tip_src_model

`default_nettype wire

/* tb_tip_pin_assign.sv */
// Purpose: Self-checking bench for the timer input pin assignment
// Assumes: Pins come from the event source model, default prescaler 3
// Notes: Output pulses are counted on the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module tb_tip_pin_assign;
   import tip_pkg::*;
   // Codes ticking internally with pins low, and with pins high
   localparam logic [15:0] TLO = 16'h8caf;
   localparam logic [15:0] THI = 16'h0ca3;
   // Codes where A loads, B captures, external clock flag and its scope
   localparam logic [15:0] LDM = 16'ha0a0;
   localparam logic [15:0] C1M = 16'h408a;
   localparam logic [15:0] ECM = 16'h6250;
   localparam logic [15:0] EKM = 16'heeff;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic want_a = 1'b0;
   logic want_b = 1'b0;
   logic pin_a, pin_b, tick, up, extc, ld, cp0, cp1;
   tip_fcode_t code = 4'h0;
   tip_esel_t esa = 2'h1;
   tip_esel_t esb = 2'h1;
   logic sdir = 1'b0;
   logic rmode = 1'b0;
   logic biv = 1'b0;
   logic [7:0] n_tick = 8'h0;
   logic [7:0] n_ld = 8'h0;
   logic [7:0] n_cp0 = 8'h0;
   logic [7:0] n_cp1 = 8'h0;
   logic up_tick = 1'b0;
   tip_fcode_t ecode [4] = '{4'h4, 4'h6, 4'h9, 4'hd};
   int miscompares = 0;
   int checked = 0;

   // ****************************************************************
   // Clock, source model and design
   // ****************************************************************
   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   tip_src_model u_tip_src_model (.clk_sys(clk_sys), .nrst(nrst),
      .want_a(want_a), .want_b(want_b), .pin_a(pin_a), .pin_b(pin_b));

   tip_pin_assign u_tip_pin_assign (.clk_sys(clk_sys), .nrst(nrst),
      .timer_input_a(pin_a), .timer_input_b(pin_b),
      .pin_function_code(code), .input_a_edge_select(esa),
      .input_b_edge_select(esb), .soft_direction_bit(sdir),
      .first_register_mode_bit(rmode), .bivalue_mode_en(biv),
      .count_tick_q(tick), .count_up_q(up), .ext_clock_q(extc),
      .load_req_q(ld), .capture0_q(cp0), .capture1_q(cp1));

   // Count pulses away from the rising edge so nothing races
   always @(negedge clk_sys)
   begin
      n_tick = n_tick + 8'(tick);
      n_ld = n_ld + 8'(ld);
      n_cp0 = n_cp0 + 8'(cp0);
      n_cp1 = n_cp1 + 8'(cp1);
      if (tick === 1'b1)
         up_tick = up;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic clr();
      n_tick = 8'h0;
      n_ld = 8'h0;
      n_cp0 = 8'h0;
      n_cp1 = 8'h0;
      up_tick = 1'bx;
   endtask : clr

   task automatic go(input logic a, input logic b, input int n);
      want_a <= a;
      want_b <= b;
      repeat (n) @(posedge clk_sys);
   endtask : go

   task automatic cfg(input tip_fcode_t c, input tip_esel_t ea,
         input tip_esel_t eb, input logic sd, input logic m,
         input logic bv);
      code <= c;
      esa <= ea;
      esb <= eb;
      sdir <= sd;
      rmode <= m;
      biv <= bv;
      @(posedge clk_sys);
   endtask : cfg

   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // ****************************************************************
   // Tests
   // ****************************************************************
   // Watchdog, well beyond the roughly 2400 cycles the tests take
   initial
   begin
      repeat (10000) @(posedge clk_sys);
      miscompares++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_sys);
      chk(8'(up), 8'h1);
      chk({3'h0, tick, extc, ld, cp0, cp1}, 8'h0);
      nrst <= 1'b1;
      for (int c = 0; c < 16; c++)
      begin
         cfg(c[3:0], 2'h1, 2'h1, 1'b0, 1'b0, 1'b0);
         go(1'b0, 1'b0, 10);
         clr();
         go(1'b0, 1'b0, 30);
         chk(n_tick, TLO[c] ? 8'ha : 8'h0);
         go(1'b1, 1'b1, 10);
         clr();
         go(1'b1, 1'b1, 30);
         chk(n_tick, THI[c] ? 8'ha : 8'h0);
         go(1'b0, 1'b0, 10);
         clr();
         go(1'b1, 1'b0, 8);
         go(1'b0, 1'b0, 8);
         chk(n_ld, 8'(LDM[c]));
         chk(n_cp0, 8'h0);
         clr();
         go(1'b0, 1'b1, 8);
         go(1'b0, 1'b0, 8);
         chk(n_cp1, 8'(C1M[c]));
         if (EKM[c])
            chk(8'(extc), 8'(ECM[c]));
      end
      // Software direction, then A level overriding it
      cfg(4'h0, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 10);
      chk(8'(up), 8'h1);
      cfg(4'hb, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 10);
      chk(8'(up), 8'h0);
      go(1'b1, 1'b0, 10);
      chk(8'(up), 8'h1);
      // Edge-set direction, B first so the software bit cannot explain it
      cfg(4'ha, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b1, 10);
      chk(8'(up), 8'h0);
      go(1'b1, 1'b0, 10);
      chk(8'(up), 8'h1);
      chk(n_ld, 8'h0);
      // Up and down step clocks
      cfg(4'h8, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0);
      go(1'b0, 1'b0, 10);
      clr();
      go(1'b1, 1'b0, 8);
      go(1'b0, 1'b0, 8);
      chk(n_tick, 8'h1);
      chk(8'(up_tick), 8'h1);
      clr();
      go(1'b0, 1'b1, 8);
      go(1'b0, 1'b0, 8);
      chk(n_tick, 8'h1);
      chk(8'(up_tick), 8'h0);
      // Autodiscrimination: B edges count only while A is low
      cfg(4'hc, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0);
      clr();
      go(1'b0, 1'b1, 8);
      chk(n_tick, 8'h1);
      chk(8'(up_tick), 8'h1);
      clr();
      go(1'b0, 1'b0, 8);
      chk(n_tick, 8'h1);
      chk(8'(up_tick), 8'h0);
      go(1'b1, 1'b0, 10);
      clr();
      go(1'b1, 1'b1, 8);
      go(1'b1, 1'b0, 8);
      chk(n_tick, 8'h0);
      // External prescaler clock on B
      foreach (ecode[i])
      begin
         cfg(ecode[i], 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b0, 8);
         clr();
         go(1'b0, 1'b1, 8);
         go(1'b0, 1'b0, 8);
         chk(n_tick, 8'h1);
         chk(8'(up_tick), 8'(ecode[i] != 4'h9));
      end
      // Gate closed on code 6, both edges on code 4
      cfg(4'h6, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
      go(1'b1, 1'b0, 10);
      clr();
      go(1'b1, 1'b1, 8);
      go(1'b1, 1'b0, 8);
      chk(n_tick, 8'h0);
      cfg(4'h4, 2'h1, 2'h3, 1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 10);
      clr();
      go(1'b0, 1'b1, 8);
      go(1'b0, 1'b0, 8);
      chk(n_tick, 8'h2);
      // A clocks the prescaler on code e
      cfg(4'he, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0);
      clr();
      go(1'b1, 1'b0, 8);
      go(1'b0, 1'b0, 8);
      chk(n_tick, 8'h1);
      chk(n_ld, 8'h0);
      // Capture mode for A, bivalue mode blocking B
      cfg(4'h5, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0);
      clr();
      go(1'b1, 1'b0, 8);
      go(1'b0, 1'b0, 8);
      chk(n_cp0, 8'h1);
      chk(n_ld, 8'h0);
      cfg(4'h7, 2'h1, 2'h1, 1'b0, 1'b0, 1'b1);
      clr();
      go(1'b1, 1'b1, 8);
      go(1'b0, 1'b0, 8);
      chk(n_cp1, 8'h0);
      chk(n_ld, 8'h1);
      // Every edge choice of A, rise first then fall
      for (int e = 0; e < 4; e++)
      begin
         cfg(4'h5, 2'(e), 2'h1, 1'b0, 1'b0, 1'b0);
         clr();
         go(1'b1, 1'b0, 8);
         chk(n_ld, 8'(e % 2));
         go(1'b0, 1'b0, 8);
         chk(n_ld, 8'(e % 2 + e / 2));
      end
      complete_run();
   end
endmodule : tb_tip_pin_assign

`default_nettype wire
